// file: rtl/rdosc_pkg.sv
// package for the prescaler and output sync control block
// assumes an apb master with 16-bit byte addresses and 32-bit data
package rdosc_pkg;

	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_COMMIT   = 16'h0005;
	localparam logic [15:0] IDX_PLL_CTRL = 16'h0405;
	localparam logic [15:0] IDX_RSVD_A   = 16'h0406;
	localparam logic [15:0] IDX_RATIO    = 16'h0407;
	localparam logic [15:0] IDX_POWER    = 16'h0408;
	localparam logic [15:0] IDX_SYNC     = 16'h0500;
	localparam logic [15:0] IDX_STATUS   = 16'h0600;

	localparam logic [15:0] ADDR_COMMIT   = {IDX_COMMIT[13:0], 2'b00};
	localparam logic [15:0] ADDR_PLL_CTRL = {IDX_PLL_CTRL[13:0], 2'b00};
	localparam logic [15:0] ADDR_RSVD_A   = {IDX_RSVD_A[13:0], 2'b00};
	localparam logic [15:0] ADDR_RATIO    = {IDX_RATIO[13:0], 2'b00};
	localparam logic [15:0] ADDR_POWER    = {IDX_POWER[13:0], 2'b00};
	localparam logic [15:0] ADDR_SYNC     = {IDX_SYNC[13:0], 2'b00};
	localparam logic [15:0] ADDR_STATUS   = {IDX_STATUS[13:0], 2'b00};

	// reset values
	localparam logic [7:0] RST_PLL_CTRL = 8'h20;
	localparam logic [7:0] RST_RSVD_A   = 8'h00;
	localparam logic [7:0] RST_RATIO    = 8'h44;
	localparam logic [7:0] RST_POWER    = 8'h02;
	localparam logic [7:0] RST_SYNC     = 8'h02;

	// writable bits of each register
	localparam logic [7:0] WM_PLL_CTRL = 8'h08;
	localparam logic [7:0] WM_RATIO    = 8'hFF;
	localparam logic [7:0] WM_POWER    = 8'h17;
	localparam logic [7:0] WM_SYNC     = 8'h37;

	// field positions
	localparam int COMMIT_BIT   = 0;
	localparam int OVERRIDE_BIT = 3;
	localparam int FIRST_LSB    = 0;
	localparam int SECOND_LSB   = 4;
	localparam int STARTUP_BIT  = 4;
	localparam int DUAL_PD_BIT  = 2;
	localparam int SECOND_PD_BIT = 1;
	localparam int FIRST_PD_BIT = 0;
	localparam int MASK0_BIT    = 4;
	localparam int MASK1_BIT    = 5;
	localparam int SRC_BIT      = 2;
	localparam int AUTO_LSB     = 0;

	// prescaler code map
	localparam logic [3:0] CODE_LOW_MAX = 4'h1;
	localparam logic [3:0] CODE_MAX     = 4'h9;
	localparam logic [3:0] CODE_RESET   = 4'hF;
	localparam logic [3:0] DIV_MIN      = 4'h3;
	localparam logic [3:0] DIV_OFFSET   = 4'h2;
	localparam logic [3:0] DIV_MAX      = 4'hB;
	localparam logic [3:0] DIV_DEFAULT  = 4'h6;

	// automatic sync trigger
	typedef enum logic [1:0] {
		AUTO_OFF   = 2'h0,
		AUTO_FREQ  = 2'h1,
		AUTO_PHASE = 2'h2,
		AUTO_RSVD  = 2'h3
	} rdosc_auto_e;

	localparam int NUM_CH    = 2;
	localparam int NUM_ASYNC = 6;

endpackage : rdosc_pkg

// file: rtl/rdosc_sync_ff.sv
// two-flop synchroniser for a group of level inputs
// assumes inputs are asynchronous to pclk; only stage two is read outside
`timescale 1ns/1ps
`default_nettype none
module rdosc_sync_ff #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : rdosc_sync_ff
`default_nettype wire

// file: rtl/rdosc_ctrl.sv
// prescaler ratio/power control and output channel sync control, apb slave
// assumes pll status inputs are asynchronous levels; channel dividers are outside
`timescale 1ns/1ps
`default_nettype none
module rdosc_ctrl (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// pll status levels
	input  wire logic        output_analog_pll_calibrated,
	input  wire logic        output_analog_pll_locked,
	input  wire logic        output_analog_pll_fb_detected,
	input  wire logic        digital_pll_freq_lock,
	input  wire logic        digital_pll_phase_lock,
	input  wire logic        ref_sync,
	// prescaler control
	output logic      [3:0]  first_prescaler_div,
	output logic      [3:0]  second_prescaler_div,
	output logic             first_prescaler_in_reset,
	output logic             second_prescaler_in_reset,
	output logic             first_prescaler_pd,
	output logic             second_prescaler_pd,
	// channel divider control
	output logic [rdosc_pkg::NUM_CH-1:0] channel_sync_hold,
	output logic [rdosc_pkg::NUM_CH-1:0] channel_restart,
	output logic             sync_armed
);
	import rdosc_pkg::*;

	logic [7:0]           pll_ctrl_q, ratio_q, power_q, sync_q;
	logic [7:0]           pll_act_q, ratio_act_q, power_act_q, sync_act_q;
	logic                 commit_q;
	logic                 sync_evt_q;
	logic [NUM_CH-1:0]    mask_prev_q;
	logic [NUM_ASYNC-1:0] async_s;
	logic                 cal_s, lock_s, fb_s, freq_s, phase_s, ref_s;
	logic                 freq_prev_q, phase_prev_q, ref_prev_q;
	logic                 wr_en, setup;
	logic                 auto_evt, ref_evt, commit_evt, sync_evt_d;
	logic [7:0]           rd8;
	logic                 unmapped;
	rdosc_auto_e          auto_mode;

	// all pll status pins cross into pclk here
	rdosc_sync_ff #(.W(NUM_ASYNC)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({output_analog_pll_calibrated, output_analog_pll_locked, output_analog_pll_fb_detected,
			digital_pll_freq_lock, digital_pll_phase_lock, ref_sync}),
		.q       (async_s)
	);
	assign {cal_s, lock_s, fb_s, freq_s, phase_s, ref_s} = async_s;

	// apb phases
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite & pready;

	// read mux and decode, sampled in the setup cycle
	always_comb begin
		rd8      = 8'h00;
		unmapped = 1'b0;
		case (paddr)
			ADDR_COMMIT:   rd8 = 8'h00;
			ADDR_PLL_CTRL: rd8 = pll_ctrl_q;
			ADDR_RSVD_A:   rd8 = RST_RSVD_A;
			ADDR_RATIO:    rd8 = ratio_q;
			ADDR_POWER:    rd8 = power_q;
			ADDR_SYNC:     rd8 = sync_q;
			ADDR_STATUS:   rd8 = {cal_s, lock_s, fb_s, second_prescaler_pd, first_prescaler_pd,
				channel_sync_hold, sync_armed};
			default:       unmapped = 1'b1;
		endcase
	end

	// answer registered at setup so the access phase ends after one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready <= setup;
			if (setup) begin
				pslverr <= unmapped;
				prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd8};
			end
		end
	end

	// staged registers; reserved bits keep their reset value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_ctrl_q <= RST_PLL_CTRL;
			ratio_q    <= RST_RATIO;
			power_q    <= RST_POWER;
			sync_q     <= RST_SYNC;
		end else if (wr_en) begin
			case (paddr)
				ADDR_PLL_CTRL: pll_ctrl_q <= (pll_ctrl_q & ~WM_PLL_CTRL) | (pwdata[7:0] & WM_PLL_CTRL);
				ADDR_RATIO:    ratio_q    <= (ratio_q & ~WM_RATIO) | (pwdata[7:0] & WM_RATIO);
				ADDR_POWER:    power_q    <= (power_q & ~WM_POWER) | (pwdata[7:0] & WM_POWER);
				ADDR_SYNC:     sync_q     <= (sync_q & ~WM_SYNC) | (pwdata[7:0] & WM_SYNC);
				default: ;
			endcase
		end
	end

	// commit strobe decode
	// self-clearing, never stored, so reads of it give zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			commit_q <= 1'b0;
		end else begin
			commit_q <= wr_en & (paddr == ADDR_COMMIT) & pwdata[COMMIT_BIT];
		end
	end

	// commit copies staged
	// active copies change only on commit, so a ratio never tears mid-write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_act_q   <= RST_PLL_CTRL;
			ratio_act_q <= RST_RATIO;
			power_act_q <= RST_POWER;
			sync_act_q  <= RST_SYNC;
		end else if (commit_q) begin
			pll_act_q   <= pll_ctrl_q;
			ratio_act_q <= ratio_q;
			power_act_q <= power_q;
			sync_act_q  <= sync_q;
		end
	end

	// code to division ratio; undefined codes clamp to the top ratio
	function automatic logic [3:0] div_of(input logic [3:0] code);
		logic [3:0] r;
		r = DIV_MAX;
		if (code <= CODE_LOW_MAX) begin
			r = DIV_MIN;
		end else if (code <= CODE_MAX) begin
			r = code + DIV_OFFSET;
		end
		return r;
	endfunction : div_of

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_prescaler_div       <= DIV_DEFAULT;
			second_prescaler_div      <= DIV_DEFAULT;
			first_prescaler_in_reset  <= 1'b0;
			second_prescaler_in_reset <= 1'b0;
		end else begin
			first_prescaler_div       <= div_of(ratio_act_q[FIRST_LSB +: 4]);
			second_prescaler_div      <= div_of(ratio_act_q[SECOND_LSB +: 4]);
			first_prescaler_in_reset  <= ratio_act_q[FIRST_LSB +: 4] == CODE_RESET;
			second_prescaler_in_reset <= ratio_act_q[SECOND_LSB +: 4] == CODE_RESET;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_prescaler_pd  <= 1'b1;
			second_prescaler_pd <= 1'b1;
		end else begin
			first_prescaler_pd  <= power_act_q[DUAL_PD_BIT] | power_act_q[FIRST_PD_BIT]
				| (~power_act_q[STARTUP_BIT] & ~fb_s);
			second_prescaler_pd <= power_act_q[DUAL_PD_BIT] | power_act_q[SECOND_PD_BIT]
				| (~power_act_q[STARTUP_BIT] & ~fb_s);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_armed <= 1'b0;
		end else begin
			sync_armed <= pll_act_q[OVERRIDE_BIT] | (cal_s & lock_s);
		end
	end

	// edge history of synchronised triggers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_prev_q  <= 1'b0;
			phase_prev_q <= 1'b0;
			ref_prev_q   <= 1'b0;
		end else begin
			freq_prev_q  <= freq_s;
			phase_prev_q <= phase_s;
			ref_prev_q   <= ref_s;
		end
	end

	assign auto_mode  = rdosc_auto_e'(sync_act_q[AUTO_LSB +: 2]);
	assign auto_evt   = ((auto_mode == AUTO_FREQ) & freq_s & ~freq_prev_q)
		| ((auto_mode == AUTO_PHASE) & phase_s & ~phase_prev_q);
	assign ref_evt    = sync_act_q[SRC_BIT] & ref_s & ~ref_prev_q;
	assign commit_evt = ~sync_q[SRC_BIT] & commit_q;
	assign sync_evt_d = sync_armed & (commit_evt | ref_evt | auto_evt);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_evt_q <= 1'b0;
		end else begin
			sync_evt_q <= sync_evt_d;
		end
	end

	// aligned restart
	// unmasking a channel freezes it again until the next sync
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_sync_hold <= {NUM_CH{1'b1}};
			channel_restart   <= {NUM_CH{1'b0}};
			mask_prev_q       <= {NUM_CH{1'b0}};
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				mask_prev_q[i]     <= sync_act_q[MASK0_BIT + i];
				channel_restart[i] <= sync_evt_q & ~sync_act_q[MASK0_BIT + i];
				if (sync_act_q[MASK0_BIT + i] | sync_evt_q) begin
					channel_sync_hold[i] <= 1'b0;
				end else if (mask_prev_q[i]) begin
					channel_sync_hold[i] <= 1'b1;
				end
			end
		end
	end

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_second_low;
		(ratio_act_q[SECOND_LSB +: 4] <= CODE_LOW_MAX) |=> (second_prescaler_div == DIV_MIN);
	endproperty
	a_second_low: assert property (p_second_low) else $error("second ratio low codes");

	property p_first_top;
		(ratio_act_q[FIRST_LSB +: 4] == CODE_MAX) |=> (first_prescaler_div == DIV_MAX);
	endproperty
	a_first_top: assert property (p_first_top) else $error("first ratio top code");

	property p_reset_code;
		commit_q && (ratio_q[FIRST_LSB +: 4] == CODE_RESET) |=> ##1 first_prescaler_in_reset;
	endproperty
	a_reset_code: assert property (p_reset_code) else $error("reset code not applied");

	property p_startup_hold;
		(!power_act_q[STARTUP_BIT] && !fb_s) |=> (first_prescaler_pd && second_prescaler_pd);
	endproperty
	a_startup_hold: assert property (p_startup_hold) else $error("start-up hold missing");

	property p_dual_pd;
		power_act_q[DUAL_PD_BIT] |=> (first_prescaler_pd && second_prescaler_pd);
	endproperty
	a_dual_pd: assert property (p_dual_pd) else $error("dual power-down ignored");

	property p_second_on;
		(power_act_q[STARTUP_BIT] && !power_act_q[DUAL_PD_BIT] && !power_act_q[SECOND_PD_BIT])
			|=> !second_prescaler_pd;
	endproperty
	a_second_on: assert property (p_second_on) else $error("second prescaler not enabled");

	property p_first_on;
		(fb_s && !power_act_q[DUAL_PD_BIT] && !power_act_q[FIRST_PD_BIT]) |=> !first_prescaler_pd;
	endproperty
	a_first_on: assert property (p_first_on) else $error("first prescaler not enabled");

	property p_hold_stays;
		(!sync_act_q[MASK0_BIT] && !mask_prev_q[0] && channel_sync_hold[0] && !sync_evt_q)
			|=> channel_sync_hold[0];
	endproperty
	a_hold_stays: assert property (p_hold_stays) else $error("channel 0 released early");

	property p_mask1;
		sync_act_q[MASK1_BIT] |=> (!channel_sync_hold[1] && !channel_restart[1]);
	endproperty
	a_mask1: assert property (p_mask1) else $error("masked channel 1 touched");

	property p_mask0;
		sync_act_q[MASK0_BIT] |=> (!channel_sync_hold[0] && !channel_restart[0]);
	endproperty
	a_mask0: assert property (p_mask0) else $error("masked channel 0 touched");

	property p_commit_sync;
		(commit_q && !sync_q[SRC_BIT] && sync_armed) |=> sync_evt_q;
	endproperty
	a_commit_sync: assert property (p_commit_sync) else $error("commit sync lost");

	property p_unarmed;
		!sync_armed |=> !sync_evt_q;
	endproperty
	a_unarmed: assert property (p_unarmed) else $error("sync while unarmed");

	property p_auto_mode;
		auto_evt |-> (auto_mode == AUTO_FREQ || auto_mode == AUTO_PHASE);
	endproperty
	a_auto_mode: assert property (p_auto_mode) else $error("auto sync in wrong mode");

	property p_override;
		pll_act_q[OVERRIDE_BIT] |=> sync_armed;
	endproperty
	a_override: assert property (p_override) else $error("override did not arm");

	property p_restart;
		(sync_evt_q && !sync_act_q[MASK0_BIT] && !sync_act_q[MASK1_BIT])
			|=> (channel_restart == 2'h3 && channel_sync_hold == 2'h0);
	endproperty
	a_restart: assert property (p_restart) else $error("channels not restarted together");

	c_commit_sync: cover property (commit_q && sync_armed ##1 sync_evt_q);
	c_auto_sync: cover property (auto_evt && sync_armed);
	c_reset_state: cover property (first_prescaler_in_reset ##[1:50] !first_prescaler_in_reset);
endmodule : rdosc_ctrl
`default_nettype wire

// file: tb/rdosc_ctrl_tb.sv
// self-checking bench for rdosc_ctrl: apb registers, prescaler control, output sync
// assumes the slave answers within a few cycles; every wait is bounded anyway
`timescale 1ns/1ps
`default_nettype none
module rdosc_ctrl_tb;
	import rdosc_pkg::*;

	logic              pclk, presetn, psel, penable, pwrite;
	logic [15:0]       paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic              pready, pslverr, er;
	logic              output_analog_pll_calibrated, output_analog_pll_locked;
	logic              output_analog_pll_fb_detected, digital_pll_freq_lock;
	logic              digital_pll_phase_lock, ref_sync;
	logic [3:0]        first_prescaler_div, second_prescaler_div;
	logic              first_prescaler_in_reset, second_prescaler_in_reset;
	logic              first_prescaler_pd, second_prescaler_pd;
	logic [NUM_CH-1:0] channel_sync_hold, channel_restart, acc;
	logic              sync_armed;
	int                fails, tests_run;

	rdosc_ctrl uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.output_analog_pll_calibrated(output_analog_pll_calibrated),
		.output_analog_pll_locked(output_analog_pll_locked),
		.output_analog_pll_fb_detected(output_analog_pll_fb_detected),
		.digital_pll_freq_lock(digital_pll_freq_lock),
		.digital_pll_phase_lock(digital_pll_phase_lock), .ref_sync(ref_sync),
		.first_prescaler_div(first_prescaler_div), .second_prescaler_div(second_prescaler_div),
		.first_prescaler_in_reset(first_prescaler_in_reset),
		.second_prescaler_in_reset(second_prescaler_in_reset),
		.first_prescaler_pd(first_prescaler_pd), .second_prescaler_pd(second_prescaler_pd),
		.channel_sync_hold(channel_sync_hold), .channel_restart(channel_restart),
		.sync_armed(sync_armed)
	);

	// 50 mhz clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// hang guard, far beyond the longest legal run
	initial begin
		#1000000;
		fails++;
		end_of_test();
	end

	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			fails++;
			end_of_test();
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdchk(input logic [15:0] a, input logic [31:0] exp, input logic experr);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk(er, experr);
	endtask : rdchk

	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : settle

	// software commit: 0x01 into the commit register
	task automatic commit;
		apb(1'b1, ADDR_COMMIT, 32'h01);
	endtask : commit

	// collects every restart pulse over n cycles; a pulse lasts one cycle only
	task automatic watch(input int n);
		acc = '0;
		repeat (n) begin
			@(posedge pclk);
			#1;
			acc |= channel_restart;
		end
	endtask : watch

	task automatic t_reset;
		rdchk(ADDR_RATIO, 32'h44, 1'b0);
		rdchk(ADDR_POWER, 32'h02, 1'b0);
		rdchk(ADDR_SYNC, 32'h02, 1'b0);
		rdchk(ADDR_PLL_CTRL, 32'h20, 1'b0);
		rdchk(ADDR_COMMIT, 32'h00, 1'b0);
		apb(1'b1, ADDR_RSVD_A, 32'hFF);
		rdchk(ADDR_RSVD_A, 32'h00, 1'b0);
		rdchk(16'h0FF0, 32'h00, 1'b1);
		chk(first_prescaler_div, 4'h6);
		chk(second_prescaler_div, 4'h6);
		chk(first_prescaler_pd, 1'b1);
		chk(second_prescaler_pd, 1'b1);
		chk(channel_sync_hold, 2'b11);
	endtask : t_reset

	// start-up mode while the feedback divider is still missing
	task automatic t_startup;
		apb(1'b1, ADDR_POWER, 32'h10);
		commit();
		settle(4);
		chk(first_prescaler_pd, 1'b0);
		chk(second_prescaler_pd, 1'b0);
		apb(1'b1, ADDR_POWER, 32'h00);
		commit();
		settle(4);
		chk(first_prescaler_pd, 1'b1);
		@(posedge pclk);
		output_analog_pll_fb_detected <= 1'b1;
		settle(8);
		chk(first_prescaler_pd, 1'b0);
	endtask : t_startup

	task automatic pw_try(input logic [7:0] v, input logic f, input logic s);
		apb(1'b1, ADDR_POWER, {24'h0, v});
		commit();
		settle(4);
		chk(first_prescaler_pd, f);
		chk(second_prescaler_pd, s);
	endtask : pw_try

	// two-step change: reset code and commit, then the new codes and commit
	task automatic ratio_step(input logic [3:0] c2, input logic [3:0] c1, input logic [3:0] e2,
				input logic [3:0] e1);
		apb(1'b1, ADDR_RATIO, 32'hFF);
		commit();
		settle(3);
		chk(second_prescaler_in_reset, 1'b1);
		chk(first_prescaler_in_reset, 1'b1);
		apb(1'b1, ADDR_RATIO, {24'h0, c2, c1});
		commit();
		settle(3);
		chk(second_prescaler_in_reset, 1'b0);
		chk(first_prescaler_in_reset, 1'b0);
		chk(second_prescaler_div, e2);
		chk(first_prescaler_div, e1);
	endtask : ratio_step

	// every defined code on both fields, then an undefined code on each field (0xA, 0xE) that clamps
	task automatic t_ratio;
		logic [3:0] c;
		for (int i = 0; i < 10; i++) begin
			c = 4'(i);
			ratio_step(c, 4'h9 - c, (c <= 4'h1) ? 4'h3 : c + 4'h2, (4'h9 - c <= 4'h1) ? 4'h3 : 4'hB - c);
		end
		ratio_step(4'hA, 4'hE, 4'hB, 4'hB);
	endtask : t_ratio

	task automatic mask_try(input logic [7:0] v, input logic [1:0] h, input logic [1:0] r);
		apb(1'b1, ADDR_SYNC, {24'h0, v});
		commit();
		watch(6);
		chk(channel_sync_hold, h);
		chk(acc, r);
	endtask : mask_try

	// trigger source with source select on the active reference
	task automatic auto_try(input logic [1:0] m, input logic f, input logic p, input logic r,
				input logic [1:0] e);
		apb(1'b1, ADDR_SYNC, {29'h0, 1'b1, m});
		commit();
		watch(6);
		chk(acc, 2'b00);
		@(posedge pclk);
		digital_pll_freq_lock  <= f;
		digital_pll_phase_lock <= p;
		ref_sync               <= r;
		watch(10);
		chk(acc, e);
		@(posedge pclk);
		digital_pll_freq_lock  <= 1'b0;
		digital_pll_phase_lock <= 1'b0;
		ref_sync               <= 1'b0;
		settle(6);
	endtask : auto_try

	task automatic t_sync;
		mask_try(8'h10, 2'b10, 2'b00);
		mask_try(8'h20, 2'b01, 2'b00);
		mask_try(8'h00, 2'b11, 2'b00);
		apb(1'b1, ADDR_PLL_CTRL, 32'h08);
		commit();
		settle(3);
		chk(sync_armed, 1'b1);
		commit();
		watch(6);
		chk(acc, 2'b11);
		mask_try(8'h10, 2'b00, 2'b10);
		mask_try(8'h00, 2'b00, 2'b11);
		mask_try(8'h00, 2'b00, 2'b11);
		apb(1'b1, ADDR_PLL_CTRL, 32'h00);
		commit();
		settle(3);
		chk(sync_armed, 1'b0);
		@(posedge pclk);
		output_analog_pll_calibrated <= 1'b1;
		settle(6);
		chk(sync_armed, 1'b0);
		@(posedge pclk);
		output_analog_pll_locked <= 1'b1;
		settle(6);
		chk(sync_armed, 1'b1);
		// status: pll inputs high, both prescalers down by the committed power word, channels running
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'hF9);
	endtask : t_sync

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{output_analog_pll_calibrated, output_analog_pll_locked, output_analog_pll_fb_detected} = '0;
		{digital_pll_freq_lock, digital_pll_phase_lock, ref_sync} = '0;
		fails = 0;
		tests_run = 0;
		presetn = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_startup();
		pw_try(8'h04, 1'b1, 1'b1);
		pw_try(8'h01, 1'b1, 1'b0);
		pw_try(8'h02, 1'b0, 1'b1);
		pw_try(8'h00, 1'b0, 1'b0);
		apb(1'b1, ADDR_POWER, 32'hFF);
		rdchk(ADDR_POWER, 32'h17, 1'b0);
		t_ratio();
		t_sync();
		auto_try(2'h0, 1'b1, 1'b1, 1'b0, 2'b00);
		auto_try(2'h1, 1'b1, 1'b0, 1'b0, 2'b11);
		auto_try(2'h1, 1'b0, 1'b1, 1'b0, 2'b00);
		auto_try(2'h2, 1'b0, 1'b1, 1'b0, 2'b11);
		auto_try(2'h2, 1'b1, 1'b0, 1'b0, 2'b00);
		auto_try(2'h3, 1'b1, 1'b1, 1'b0, 2'b00);
		auto_try(2'h0, 1'b0, 1'b0, 1'b1, 2'b11);
		end_of_test();
	end

endmodule : rdosc_ctrl_tb
`default_nettype wire
